// file: rtl/dlp_pkg.sv
// Package with constants and types of the deterministic-latency option logic.
package dlp_pkg;
	localparam int WORD_W = 10;
	localparam logic [9:0] COMMA_PAT = 10'h0fa;
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RUNLEN = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	// Control bit positions.
	localparam int CTRL_RLV_EN = 0;
	localparam int CTRL_ALIGN_STAT_EN = 1;
	localparam int CTRL_CODEC_STAT_EN = 2;
	localparam int CTRL_PMA_STAT_EN = 3;
	localparam int CTRL_EMB_RST_EN = 4;
	localparam int CTRL_MANUAL = 5;
	localparam int CTRL_REALIGN = 6;
	localparam logic [5:0] CTRL_RESET = 6'h10;
	// Interrupt bit positions.
	localparam int IRQ_RLV = 0;
	localparam int IRQ_SYNC = 1;
	localparam int IRQ_CODE = 2;
	localparam int IRQ_DISP = 3;
	// Run-length limits.
	localparam logic [7:0] RUNLEN_MIN = 8'h05;
	localparam logic [7:0] RUNLEN_MAX = 8'ha0;
	localparam logic [7:0] RUNLEN_STEP = 8'h05;
	localparam logic [7:0] RUNLEN_RESET = 8'ha0;
	// Reset sequencer hold time.
	localparam int CLK_PERIOD_NS = 50;
	localparam int RST_HOLD_NS = 1000;
	localparam logic [4:0] RST_HOLD_CYC =
		5'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [3:0] {
		RS_ANALOG = 4'h1,
		RS_CAL = 4'h2,
		RS_DIG = 4'h4,
		RS_RUN = 4'h8
	} dlp_rst_state_type;

	typedef enum logic [1:0] {
		AL_HUNT = 2'h1,
		AL_SYNC = 2'h2
	} dlp_align_state_type;

	typedef struct packed {
		logic txAnalog;
		logic txDigital;
		logic rxAnalog;
		logic rxDigital;
	} dlp_rst_type;

	typedef struct packed {
		logic runDisp;
		logic codeErr;
		logic dispErr;
	} dlp_codec_type;

	typedef struct packed {
		logic viol;
		logic lastBit;
		logic [7:0] cnt;
	} dlp_rl_type;
endpackage

// file: rtl/dlp_option_logic.sv
// Receive checks, word aligner, transmit slipper and reset sequencing.
`timescale 1ns/1ps
module dlp_option_logic
	import dlp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// Receive parallel data
	input wire logic [9:0] rxWord,
	output logic [9:0] rxAlignedWord,
	output logic [4:0] rxSlipBoundary,
	output logic rxRlv,
	output logic rxPatternDetect,
	output logic rxSyncStatus,
	output dlp_codec_type rxCodec,
	// PMA status
	input wire logic cdrRefLock,
	input wire logic cdrDataLock,
	input wire logic rxSignalDetect,
	output logic cdrRefLockOut,
	output logic cdrDataLockOut,
	output logic rxSignalDetectOut,
	// Transmit parallel data
	input wire logic [9:0] txWordIn,
	output logic [9:0] txWordOut,
	// Channel resets
	input wire dlp_rst_type extRst,
	input wire logic txCalBusy,
	input wire logic rxCalBusy,
	output dlp_rst_type chanRst
);

	function automatic dlp_rl_type rl_step(input logic [9:0] w,
		input dlp_rl_type s, input logic [7:0] thr);
		dlp_rl_type r;
		r = s;
		r.viol = 1'b0;
		for (int i = 0; i < WORD_W; i++) begin
			if (w[i] == r.lastBit && r.cnt != 8'hff) begin
				r.cnt = r.cnt + 8'h01;
			end else if (w[i] != r.lastBit) begin
				r.cnt = 8'h01;
			end
			r.lastBit = w[i];
			if (r.cnt > thr) begin
				r.viol = 1'b1;
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] ones10(input logic [9:0] w);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < WORD_W; i++) begin
			n = n + {3'h0, w[i]};
		end
		return n;
	endfunction

	logic [5:0] ctrlReg;
	logic [7:0] runLenReg;
	logic [3:0] irqStatReg;
	logic [3:0] irqMaskReg;
	logic realignPulse;
	logic apbAccess;
	logic apbDone;
	logic [31:0] rdValue;
	logic mapped;

	assign apbAccess = psel && penable && !pready;
	assign apbDone = psel && penable && pready;
	assign mapped = paddr inside {OFF_CTRL, OFF_RUNLEN, OFF_STATUS,
		OFF_IRQ_STAT, OFF_IRQ_MASK};

	// One wait state lets read data come straight from a flip-flop.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= apbAccess;
			pslverr <= apbAccess && !mapped;
			if (apbAccess && !pwrite) begin
				prdata <= rdValue;
			end
		end
	end

	logic [7:0] wrLen;
	assign wrLen = pwdata[7:0];

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlReg <= CTRL_RESET;
			runLenReg <= RUNLEN_RESET;
			irqMaskReg <= 4'h0;
			realignPulse <= 1'b0;
		end else begin
			realignPulse <= 1'b0;
			if (apbDone && pwrite) begin
				if (paddr == OFF_CTRL) begin
					ctrlReg <= pwdata[5:0];
					realignPulse <= pwdata[CTRL_REALIGN];
				end
				// Out-of-range or non-multiple values leave the threshold alone.
				if (paddr == OFF_RUNLEN && wrLen >= RUNLEN_MIN &&
					wrLen <= RUNLEN_MAX && wrLen % RUNLEN_STEP == 8'h00) begin
					runLenReg <= wrLen;
				end
				if (paddr == OFF_IRQ_MASK) begin
					irqMaskReg <= pwdata[3:0];
				end
			end
		end
	end

	// Reset sequencer.
	dlp_rst_state_type rstState;
	logic [4:0] rstCnt;
	logic embRst;
	assign embRst = ctrlReg[CTRL_EMB_RST_EN];

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstState <= RS_ANALOG;
			rstCnt <= 5'h0;
		end else begin
			unique case (rstState)
				RS_ANALOG: begin
					rstCnt <= rstCnt + 5'h01;
					if (rstCnt == RST_HOLD_CYC - 5'h01) begin
						rstState <= RS_CAL;
						rstCnt <= 5'h0;
					end
				end
				RS_CAL: begin
					if (!txCalBusy && !rxCalBusy) begin
						rstState <= RS_DIG;
					end
				end
				RS_DIG: begin
					rstCnt <= rstCnt + 5'h01;
					if (rstCnt == RST_HOLD_CYC - 5'h01) begin
						rstState <= RS_RUN;
						rstCnt <= 5'h0;
					end
				end
				RS_RUN: begin
					if (txCalBusy || rxCalBusy) begin
						rstState <= RS_CAL;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			chanRst <= '1;
		end else if (embRst) begin
			chanRst.txAnalog <= rstState == RS_ANALOG;
			chanRst.rxAnalog <= rstState == RS_ANALOG;
			chanRst.txDigital <= rstState != RS_RUN;
			chanRst.rxDigital <= rstState != RS_RUN;
		end else begin
			chanRst <= extRst;
		end
	end

	// Word aligner.
	dlp_align_state_type alState;
	logic [9:0] rxPrev;
	logic [19:0] rxWin;
	logic found;
	logic [3:0] foundOff;
	logic [4:0] slipReg;
	logic manual;
	assign manual = ctrlReg[CTRL_MANUAL];
	assign rxWin = {rxWord, rxPrev};

	always_comb begin
		found = 1'b0;
		foundOff = 4'h0;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			if (rxWin[i +: 10] == COMMA_PAT || rxWin[i +: 10] == ~COMMA_PAT) begin
				found = 1'b1;
				foundOff = 4'(i);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			alState <= AL_HUNT;
			slipReg <= 5'h0;
			rxPrev <= 10'h0;
			rxAlignedWord <= 10'h0;
		end else begin
			rxPrev <= rxWord;
			rxAlignedWord <= rxWin[slipReg +: 10];
			if (chanRst.rxDigital || realignPulse) begin
				alState <= AL_HUNT;
			end else begin
				unique case (alState)
					AL_HUNT: begin
						if (found) begin
							alState <= AL_SYNC;
							slipReg <= {1'b0, foundOff};
						end
					end
					AL_SYNC: begin
						if (manual && found && {1'b0, foundOff} != slipReg) begin
							slipReg <= {1'b0, foundOff};
						end
					end
				endcase
			end
		end
	end

	logic patDet;
	assign patDet = found && alState == AL_SYNC && {1'b0, foundOff} == slipReg;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxPatternDetect <= 1'b0;
			rxSyncStatus <= 1'b0;
			rxSlipBoundary <= 5'h0;
		end else begin
			rxSlipBoundary <= slipReg;
			rxPatternDetect <= ctrlReg[CTRL_ALIGN_STAT_EN] && patDet;
			rxSyncStatus <= ctrlReg[CTRL_ALIGN_STAT_EN] && alState == AL_SYNC;
		end
	end

	// Transmit bit slipper delays the stream by the receive slip in manual mode only; otherwise txWordIn passes through unslipped.
	logic [9:0] txPrev;
	logic [19:0] txWin;
	logic txSlipOn;
	assign txWin = {txWordIn, txPrev};
	assign txSlipOn = manual;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			txPrev <= 10'h0;
			txWordOut <= 10'h0;
		end else begin
			txPrev <= txWordIn;
			if (txSlipOn) begin
				txWordOut <= txWin[5'd10 - slipReg +: 10];
			end else begin
				txWordOut <= txWordIn;
			end
		end
	end

	// Run-length checking over the raw received stream.
	dlp_rl_type rlState;
	dlp_rl_type rlNext;
	assign rlNext = rl_step(rxWord, rlState, runLenReg);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rlState <= '0;
			rxRlv <= 1'b0;
		end else begin
			rlState <= rlNext;
			rxRlv <= ctrlReg[CTRL_RLV_EN] && rlNext.viol;
		end
	end

	// Codec status on the aligned word.
	logic [3:0] ones;
	logic codeBad;
	logic dispBad;
	logic runDisp;
	assign ones = ones10(rxAlignedWord);
	assign codeBad = ones < 4'h4 || ones > 4'h6;
	assign dispBad = (ones == 4'h6 && runDisp) || (ones == 4'h4 && !runDisp);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			runDisp <= 1'b0;
			rxCodec <= '0;
		end else begin
			if (!codeBad && ones != 4'h5) begin
				runDisp <= ones == 4'h6;
			end
			if (ctrlReg[CTRL_CODEC_STAT_EN]) begin
				rxCodec <= '{runDisp, codeBad, dispBad};
			end else begin
				rxCodec <= '0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cdrRefLockOut <= 1'b0;
			cdrDataLockOut <= 1'b0;
			rxSignalDetectOut <= 1'b0;
		end else begin
			cdrRefLockOut <= ctrlReg[CTRL_PMA_STAT_EN] && cdrRefLock;
			cdrDataLockOut <= ctrlReg[CTRL_PMA_STAT_EN] && cdrDataLock;
			rxSignalDetectOut <= ctrlReg[CTRL_PMA_STAT_EN] && rxSignalDetect;
		end
	end

	// Sticky events; a read clears, but a new event in that cycle survives.
	logic [3:0] irqEvents;
	logic irqRead;
	assign irqEvents = {dispBad, codeBad, alState == AL_HUNT && found,
		rlNext.viol && ctrlReg[CTRL_RLV_EN]};
	assign irqRead = apbDone && !pwrite && paddr == OFF_IRQ_STAT;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqStatReg <= 4'h0;
			irq <= 1'b0;
		end else begin
			irqStatReg <= (irqRead ? 4'h0 : irqStatReg) | irqEvents;
			irq <= |(((irqRead ? 4'h0 : irqStatReg) | irqEvents) & irqMaskReg);
		end
	end

	always_comb begin
		rdValue = 32'h0;
		unique case (paddr)
			OFF_CTRL: rdValue = {26'h0, ctrlReg};
			OFF_RUNLEN: rdValue = {24'h0, runLenReg};
			OFF_STATUS: rdValue = {21'h0, rstState == RS_RUN, rxSignalDetect,
				cdrDataLock, cdrRefLock, runDisp, alState == AL_SYNC, slipReg};
			OFF_IRQ_STAT: rdValue = {28'h0, irqStatReg};
			OFF_IRQ_MASK: rdValue = {28'h0, irqMaskReg};
			default: rdValue = 32'h0;
		endcase
	end

	property p_slip_manual;
		@(posedge ref_clk) disable iff (!arst_n)
		manual |=> txWordOut == $past(txWin[5'd10 - slipReg +: 10]);
	endproperty
	a_slip_manual: assert property (p_slip_manual)
		else $error("tx slip output wrong in manual mode");

	property p_slip_off;
		@(posedge ref_clk) disable iff (!arst_n)
		!manual |=> txWordOut == $past(txWordIn);
	endproperty
	a_slip_off: assert property (p_slip_off)
		else $error("tx slip active outside manual mode");

	property p_rlv_cause;
		@(posedge ref_clk) disable iff (!arst_n)
		rxRlv |-> $past(rlNext.cnt > runLenReg || rlNext.viol)
			&& $past(ctrlReg[CTRL_RLV_EN]);
	endproperty
	a_rlv_cause: assert property (p_rlv_cause)
		else $error("run-length violation without cause");

	property p_rlv_hit;
		@(posedge ref_clk) disable iff (!arst_n)
		ctrlReg[CTRL_RLV_EN] && rlNext.cnt > runLenReg |=> rxRlv;
	endproperty
	a_rlv_hit: assert property (p_rlv_hit)
		else $error("run-length violation missed");

	property p_runlen_legal;
		@(posedge ref_clk) disable iff (!arst_n)
		runLenReg >= RUNLEN_MIN && runLenReg <= RUNLEN_MAX
			&& runLenReg % RUNLEN_STEP == 8'h00;
	endproperty
	a_runlen_legal: assert property (p_runlen_legal)
		else $error("illegal run-length threshold");

	property p_align_gate;
		@(posedge ref_clk) disable iff (!arst_n)
		!ctrlReg[CTRL_ALIGN_STAT_EN] |=> !rxSyncStatus && !rxPatternDetect;
	endproperty
	a_align_gate: assert property (p_align_gate)
		else $error("aligner status shown while disabled");

	property p_codec_gate;
		@(posedge ref_clk) disable iff (!arst_n)
		!ctrlReg[CTRL_CODEC_STAT_EN] |=> rxCodec == '0;
	endproperty
	a_codec_gate: assert property (p_codec_gate)
		else $error("codec status shown while disabled");

	property p_pma_pass;
		@(posedge ref_clk) disable iff (!arst_n)
		ctrlReg[CTRL_PMA_STAT_EN] |=> cdrDataLockOut == $past(cdrDataLock);
	endproperty
	a_pma_pass: assert property (p_pma_pass)
		else $error("data lock status not passed through");

	property p_emb_rst;
		@(posedge ref_clk) disable iff (!arst_n)
		embRst && rstState == RS_ANALOG |=> chanRst.rxAnalog && chanRst.txDigital;
	endproperty
	a_emb_rst: assert property (p_emb_rst)
		else $error("channel resets released too early");

	property p_hunt_lock;
		@(posedge ref_clk) disable iff (!arst_n)
		alState == AL_HUNT && found && !chanRst.rxDigital && !realignPulse
			|=> alState == AL_SYNC && slipReg == {1'b0, $past(foundOff)};
	endproperty
	a_hunt_lock: assert property (p_hunt_lock)
		else $error("aligner did not lock on found comma");

endmodule // dlp_option_logic

// file: test/dlp_far_end.sv
// Far-end model: remote transceiver words, lock flags and outside resets.
`timescale 1ns/1ps
module dlp_far_end
	import dlp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Bench requests
	input wire logic [9:0] sendWord,
	input wire logic lockIn,
	input wire dlp_rst_type rstReq,
	input wire logic txCalBusy,
	input wire logic rxCalBusy,
	// Toward the block
	output logic [9:0] rxWord,
	output logic cdrRefLock,
	output logic cdrDataLock,
	output logic rxSignalDetect,
	output dlp_rst_type extRst
);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxWord <= 10'h000;
		end else begin
			rxWord <= sendWord;
		end
	end

	assign cdrRefLock = lockIn;
	assign cdrDataLock = lockIn;
	assign rxSignalDetect = lockIn;

	// Calibration must finish before a channel leaves reset.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			extRst <= '1;
		end else begin
			extRst.txAnalog <= rstReq.txAnalog | txCalBusy;
			extRst.txDigital <= rstReq.txDigital | txCalBusy;
			extRst.rxAnalog <= rstReq.rxAnalog | rxCalBusy;
			extRst.rxDigital <= rstReq.rxDigital | rxCalBusy;
		end
	end
endmodule // dlp_far_end

// file: test/tb.sv
// Self-checking testbench of the option logic.
`timescale 1ns/1ps
module tb;
	import dlp_pkg::*;
	logic ref_clk = 0, arst_n = 0;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, irq, rxRlv, rxPatternDetect, rxSyncStatus;
	logic [9:0] rxWord, rxAlignedWord, sendWord = 10'h155;
	logic [9:0] txWordIn = 10'h2b1, txWordOut;
	logic [4:0] rxSlipBoundary;
	dlp_codec_type rxCodec;
	logic cdrRefLock, cdrDataLock, rxSignalDetect, lockIn = 0;
	logic cdrRefLockOut, cdrDataLockOut, rxSignalDetectOut, err, seen;
	logic txCalBusy = 0, rxCalBusy = 0;
	dlp_rst_type extRst, chanRst, rstReq = '0;
	int nFail = 0, checksDone = 0;
	typedef struct {logic [7:0] a; logic [31:0] d, e; logic er;} row_type;
	row_type rows[8] = '{'{OFF_RUNLEN, 'h0a, 'h0a, 0}, '{OFF_RUNLEN, 'h07, 'h0a, 0},
		'{OFF_RUNLEN, 'h00, 'h0a, 0}, '{OFF_RUNLEN, 'ha5, 'h0a, 0},
		'{OFF_RUNLEN, 'ha0, 'ha0, 0}, '{OFF_RUNLEN, 'h05, 'h05, 0},
		'{8'h14, 'h1, 'h0, 1}, '{OFF_CTRL, 'h5d, 'h1d, 0}};

	always #25 ref_clk = ~ref_clk;

	dlp_far_end far (.ref_clk(ref_clk), .arst_n(arst_n), .sendWord(sendWord),
		.lockIn(lockIn), .rstReq(rstReq), .txCalBusy(txCalBusy),
		.rxCalBusy(rxCalBusy), .rxWord(rxWord), .cdrRefLock(cdrRefLock),
		.cdrDataLock(cdrDataLock), .rxSignalDetect(rxSignalDetect),
		.extRst(extRst));

	dlp_option_logic DUT (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.rxWord(rxWord), .rxAlignedWord(rxAlignedWord),
		.rxSlipBoundary(rxSlipBoundary), .rxRlv(rxRlv),
		.rxPatternDetect(rxPatternDetect), .rxSyncStatus(rxSyncStatus),
		.rxCodec(rxCodec), .cdrRefLock(cdrRefLock), .cdrDataLock(cdrDataLock),
		.rxSignalDetect(rxSignalDetect), .cdrRefLockOut(cdrRefLockOut),
		.cdrDataLockOut(cdrDataLockOut), .rxSignalDetectOut(rxSignalDetectOut),
		.txWordIn(txWordIn), .txWordOut(txWordOut), .extRst(extRst),
		.txCalBusy(txCalBusy), .rxCalBusy(rxCalBusy), .chanRst(chanRst));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			nFail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d failures %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// The request is held until pready is sampled high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic watchRlv(input int n);
		seen = 0;
		repeat (n) begin
			@(posedge ref_clk);
			if (rxRlv === 1'b1)
				seen = 1;
		end
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		nFail++;
		test_done;
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		chk(chanRst, 4'hf);
		arst_n <= 1;
		repeat (10) @(posedge ref_clk);
		chk(chanRst.txAnalog, 1);
		apb(0, OFF_CTRL, 0);
		chk(r, 32'h10);
		apb(0, OFF_RUNLEN, 0);
		chk(r, 32'ha0);
		for (int i = 0; i < 100 && chanRst !== 4'h0; i++) @(posedge ref_clk);
		chk(chanRst, 4'h0);
		apb(0, OFF_STATUS, 0);
		chk(r[10], 1);
		// Aligned commas: the aligner locks on its own at offset zero.
		apb(1, OFF_CTRL, 32'h12);
		sendWord <= COMMA_PAT;
		for (int i = 0; i < 30 && rxSyncStatus !== 1; i++) @(posedge ref_clk);
		chk(rxSyncStatus, 1);
		chk(rxPatternDetect, 1);
		chk(rxSlipBoundary, 5'h00);
		chk(txWordOut, txWordIn);
		chk(rxCodec, 3'h0);
		chk(cdrRefLockOut, 0);
		// Manual mode with the comma three bits late.
		apb(1, OFF_CTRL, 32'h72);
		sendWord <= {COMMA_PAT[6:0], COMMA_PAT[9:7]};
		for (int i = 0; i < 30 && rxSlipBoundary !== 5'h03; i++)
			@(posedge ref_clk);
		chk(rxSlipBoundary, 5'h03);
		repeat (3) @(posedge ref_clk);
		chk(txWordOut, {txWordIn[6:0], txWordIn[9:7]});
		chk(rxAlignedWord, COMMA_PAT);
		// Register table rows; the last leaves run, codec and PMA status on.
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			chk(err, rows[i].er);
			apb(0, rows[i].a, 0);
			chk(r, rows[i].e);
		end
		lockIn <= 1;
		repeat (3) @(posedge ref_clk);
		chk({cdrRefLockOut, cdrDataLockOut, rxSignalDetectOut}, 3'h7);
		// Repeated six-ones commas give a disparity error on every word.
		chk(rxCodec, 3'h5);
		// Runs of exactly five pass, runs of six are flagged.
		apb(1, OFF_IRQ_MASK, 32'h1);
		sendWord <= 10'h3e0;
		repeat (4) @(posedge ref_clk);
		apb(0, OFF_IRQ_STAT, 0);
		watchRlv(8);
		chk(seen, 0);
		chk(irq, 0);
		sendWord <= 10'h3c0;
		watchRlv(8);
		chk(seen, 1);
		chk(irq, 1);
		sendWord <= 10'h3e0;
		repeat (4) @(posedge ref_clk);
		apb(0, OFF_IRQ_STAT, 0);
		chk(r[0], 1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 0);
		// Outside reset control, held while calibration runs.
		apb(1, OFF_CTRL, 32'h0);
		txCalBusy <= 1;
		repeat (4) @(posedge ref_clk);
		chk(chanRst, 4'hc);
		txCalBusy <= 0;
		rstReq <= 4'h5;
		repeat (4) @(posedge ref_clk);
		chk(chanRst, 4'h5);
		test_done;
	end
endmodule // tb
